/* File: logic/sd10_serdes.sv */
`timescale 1ns/1ps
`default_nettype none
module sd10_serdes (
  input wire logic CLK, // 25 MHz system clock
  input wire logic RESETN, // asynchronous reset, active low
  input wire logic TRANSMIT_CLOCK, // word clock from the data source
  input wire logic TX_EDGE_SELECT, // high: rising latch edge
  input wire logic SYNC_REQUEST_A, // sync request
  input wire logic SYNC_REQUEST_B, // sync request
  input wire logic [9:0] PARALLEL_IN, // word to send
  input wire logic SERIAL_DRIVER_ENABLE, // high enables link driver
  input wire logic TX_POWER_DOWN_N, // serializer power-down, active low
  output var sd10_pkg::sd10_ser_link_t SER_LINK, // frame word, strobe, enable
  input wire logic RX_LINK_CLOCK, // partner word clock, rising edge
  input wire logic [11:0] RX_LINK_WORD, // partner frame word
  input wire logic RX_EDGE_SELECT, // high: rising strobe edge
  input wire logic RX_POWER_DOWN_N, // deserializer power-down, active low, takes effect only while RX_OUTPUT_ENABLE is low
  input wire logic RX_OUTPUT_ENABLE, // high enables parallel outputs
  output var sd10_pkg::sd10_rx_out_t RX_OUT // parallel word, clock, lock
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  function automatic logic [11:0] frame_at(input logic [23:0] s, input logic [3:0] p);
    logic [23:0] sh;
    sh = s >> p;
    return sh[11:0];
  endfunction : frame_at

  logic [15:0] tx_raw;
  logic [15:0] tx_s;
  logic [15:0] rx_raw;
  logic [15:0] rx_s;

  assign tx_raw = {PARALLEL_IN, TX_POWER_DOWN_N, SERIAL_DRIVER_ENABLE, SYNC_REQUEST_B,
                   SYNC_REQUEST_A, TX_EDGE_SELECT, TRANSMIT_CLOCK};
  assign rx_raw = {RX_LINK_WORD, RX_OUTPUT_ENABLE, RX_POWER_DOWN_N, RX_EDGE_SELECT,
                   RX_LINK_CLOCK};

  sd10_sync #(.WIDTH(16)) u_tx_sync (.clk(CLK), .reset_n(RESETN), .d(tx_raw), .q(tx_s));
  sd10_sync #(.WIDTH(16)) u_rx_sync (.clk(CLK), .reset_n(RESETN), .d(rx_raw), .q(rx_s));

  // ---------------- serializer ----------------
  logic transmit_clock_q;
  logic tx_ev;
  logic req_any;
  logic tx_pd_n_s;
  logic den_s;
  logic [9:0] din_s;
  logic [2:0] req_cnt_q;
  logic [10:0] init_cnt_q;
  logic [10:0] burst_cnt_q;
  logic [11:0] ser_word_q;
  logic ser_strobe_q;
  logic ser_oe_n_q;
  sd10_pkg::sd10_ser_state_t ser_st_q;
  sd10_pkg::sd10_ser_state_t ser_st_d;

  assign req_any = tx_s[2] | tx_s[3];
  assign den_s = tx_s[4];
  assign tx_pd_n_s = tx_s[5];
  assign din_s = tx_s[15:6];

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) transmit_clock_q <= 1'b0;
    else transmit_clock_q <= tx_s[0];
  end

  assign tx_ev = tx_s[1] ? (tx_s[0] & ~transmit_clock_q) : (~tx_s[0] & transmit_clock_q);

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      req_cnt_q <= 3'h0;
    end else if (!req_any) begin
      req_cnt_q <= 3'h0;
    end else if (tx_ev && req_cnt_q != sd10_pkg::SYNC_HOLD_CYCLES) begin
      req_cnt_q <= req_cnt_q + 3'h1;
    end
  end

  always_comb begin
    ser_st_d = ser_st_q;
    unique case (ser_st_q)
      sd10_pkg::SER_INIT: begin
        if (tx_ev && init_cnt_q == sd10_pkg::INIT_LAST) ser_st_d = sd10_pkg::SER_DATA;
      end
      sd10_pkg::SER_DATA: begin
        if (req_cnt_q == sd10_pkg::SYNC_HOLD_CYCLES) ser_st_d = sd10_pkg::SER_BURST;
      end
      sd10_pkg::SER_BURST: begin
        if (tx_ev && burst_cnt_q == sd10_pkg::SYNC_BURST_LAST) begin
          ser_st_d = req_any ? sd10_pkg::SER_HOLD : sd10_pkg::SER_DATA;
        end
      end
      sd10_pkg::SER_HOLD: begin
        if (!req_any) ser_st_d = sd10_pkg::SER_DATA;
      end
    endcase
    if (!tx_pd_n_s) ser_st_d = sd10_pkg::SER_INIT;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) ser_st_q <= sd10_pkg::SER_INIT;
    else ser_st_q <= ser_st_d;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      init_cnt_q <= 11'h000;
    end else if (ser_st_q != sd10_pkg::SER_INIT || !tx_pd_n_s) begin
      init_cnt_q <= 11'h000;
    end else if (tx_ev) begin
      init_cnt_q <= init_cnt_q + 11'h001;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      burst_cnt_q <= 11'h000;
    end else if (ser_st_q != sd10_pkg::SER_BURST) begin
      burst_cnt_q <= 11'h000;
    end else if (tx_ev) begin
      burst_cnt_q <= burst_cnt_q + 11'h001;
    end
  end

  // framing bits, bit order, sync pattern
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ser_word_q <= 12'h000;
    end else if (tx_ev) begin
      if (ser_st_q == sd10_pkg::SER_BURST || ser_st_q == sd10_pkg::SER_HOLD) begin
        ser_word_q <= sd10_pkg::SYNC_PATTERN;
      end else begin
        ser_word_q <= {sd10_pkg::STOP_BIT, din_s, sd10_pkg::START_BIT};
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) ser_strobe_q <= 1'b0;
    else ser_strobe_q <= tx_ev && ser_st_q != sd10_pkg::SER_INIT && tx_pd_n_s;
  end

  // driver gating; enable leaves the state machine alone
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ser_oe_n_q <= 1'b1;
    end else begin
      ser_oe_n_q <= !(den_s && tx_pd_n_s && ser_st_q != sd10_pkg::SER_INIT &&
                      (ser_st_q != sd10_pkg::SER_DATA || !req_any));
    end
  end

  assign SER_LINK = '{oe_n: ser_oe_n_q, strobe: ser_strobe_q, word: ser_word_q};

  // ---------------- deserializer ----------------
  logic lclk_q;
  logic rx_ev;
  logic rx_sel_s;
  logic ren_s;
  logic rx_pd;
  logic [11:0] prev_word_q;
  logic [23:0] stream;
  logic [11:0] cand;
  logic [11:0] rx_frame;
  logic repetitive_multitransition;
  logic unique_hit;
  logic [3:0] hit_pos;
  logic [3:0] pos_q;
  logic [2:0] match_cnt_q;
  logic [2:0] miss_cnt_q;
  logic [9:0] rx_data_q;
  logic [2:0] strobe_cnt_q;
  logic rclk_q;
  logic rclk_en;
  logic par_oe_n_q;
  logic lock_n_q;
  logic lock_oe_n_q;
  sd10_pkg::sd10_des_state_t des_st_q;
  sd10_pkg::sd10_des_state_t des_st_d;

  assign rx_sel_s = rx_s[1];
  assign ren_s = rx_s[3];
  assign rx_pd = !rx_s[2] && !ren_s;
  assign stream = {rx_s[15:4], prev_word_q};
  assign rx_frame = frame_at(stream, pos_q);

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) lclk_q <= 1'b0;
    else lclk_q <= rx_s[0];
  end
  assign rx_ev = rx_s[0] & ~lclk_q;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) prev_word_q <= 12'h000;
    else if (rx_ev) prev_word_q <= rx_s[15:4];
  end

  // a boundary candidate is a high start with a low stop eleven bits later
  for (genvar p = 0; p < sd10_pkg::FRAME_W; p++) begin : g_cand
    assign cand[p] = stream[p] == sd10_pkg::START_BIT && stream[p+11] == sd10_pkg::STOP_BIT;
  end

  // more than one candidate is a possible false lock
  assign repetitive_multitransition = (cand & (cand - 12'h001)) != 12'h000;
  assign unique_hit = cand != 12'h000 && !repetitive_multitransition;

  always_comb begin
    hit_pos = 4'h0;
    for (int i = sd10_pkg::FRAME_W - 1; i >= 0; i--) begin
      if (cand[i]) hit_pos = 4'(i);
    end
  end

  always_comb begin
    des_st_d = des_st_q;
    unique case (des_st_q)
      sd10_pkg::DES_HUNT: begin
        if (rx_ev && unique_hit && hit_pos == pos_q &&
            match_cnt_q == sd10_pkg::LOCK_MATCH - 3'h1) begin
          des_st_d = sd10_pkg::DES_LOCK;
        end
      end
      sd10_pkg::DES_LOCK: begin
        if (rx_ev && !cand[pos_q] && miss_cnt_q == sd10_pkg::LOSS_MISS - 3'h1) begin
          des_st_d = sd10_pkg::DES_HUNT;
        end
      end
    endcase
    if (rx_pd) des_st_d = sd10_pkg::DES_HUNT;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) des_st_q <= sd10_pkg::DES_HUNT;
    else des_st_q <= des_st_d;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pos_q <= 4'h0;
      match_cnt_q <= 3'h0;
    end else if (rx_pd || des_st_q == sd10_pkg::DES_LOCK) begin
      match_cnt_q <= 3'h0;
    end else if (rx_ev) begin
      if (!unique_hit) begin
        match_cnt_q <= 3'h0;
      end else if (hit_pos == pos_q && match_cnt_q != 3'h0) begin
        match_cnt_q <= match_cnt_q + 3'h1;
      end else begin
        pos_q <= hit_pos;
        match_cnt_q <= 3'h1;
      end
    end
  end

  // once locked, only the locked position is checked
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) miss_cnt_q <= 3'h0;
    else if (rx_pd || des_st_q != sd10_pkg::DES_LOCK) miss_cnt_q <= 3'h0;
    else if (rx_ev) miss_cnt_q <= cand[pos_q] ? 3'h0 : miss_cnt_q + 3'h1;
  end

  // capture the word, then shape the strobe after it settles
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_data_q <= 10'h000;
      strobe_cnt_q <= 3'h0;
    end else if (rx_ev && des_st_q == sd10_pkg::DES_LOCK && !rx_pd) begin
      rx_data_q <= rx_frame[10:1];
      strobe_cnt_q <= 3'h1;
    end else if (strobe_cnt_q == sd10_pkg::RCLK_END_CYC) begin
      strobe_cnt_q <= 3'h0;
    end else if (strobe_cnt_q != 3'h0) begin
      strobe_cnt_q <= strobe_cnt_q + 3'h1;
    end
  end

  // clock runs only when locked and enabled
  assign rclk_en = des_st_q == sd10_pkg::DES_LOCK && ren_s && !rx_pd;

  // strobe edge polarity; the idle level is the opposite of the strobe edge
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) rclk_q <= 1'b1;
    else if (rclk_en && strobe_cnt_q >= sd10_pkg::RCLK_SETUP_CYC) rclk_q <= rx_sel_s;
    else rclk_q <= !rx_sel_s;
  end

  // enable gating, float while unlocked, float in power-down
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      par_oe_n_q <= 1'b1;
      lock_oe_n_q <= 1'b1;
    end else begin
      par_oe_n_q <= !rclk_en;
      lock_oe_n_q <= rx_pd;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) lock_n_q <= 1'b1;
    else lock_n_q <= des_st_q != sd10_pkg::DES_LOCK;
  end

  assign RX_OUT = '{parallel_out: rx_data_q, parallel_oe_n: par_oe_n_q,
                    recovered_clock: rclk_q, recovered_clock_oe_n: par_oe_n_q,
                    lock_n: lock_n_q, lock_oe_n: lock_oe_n_q};

  // ---------------- checks ----------------
  property p_ser_pd_float;
    !tx_pd_n_s |=> ser_oe_n_q && ser_st_q == sd10_pkg::SER_INIT;
  endproperty
  a_ser_pd_float: assert property (p_ser_pd_float) else $error("serializer drives in power-down");

  property p_burst_start;
    ser_st_q == sd10_pkg::SER_DATA && req_cnt_q == sd10_pkg::SYNC_HOLD_CYCLES && tx_pd_n_s
      |=> ser_st_q == sd10_pkg::SER_BURST;
  endproperty
  a_burst_start: assert property (p_burst_start) else $error("qualified sync did not start burst");

  property p_burst_pattern;
    ser_st_q == sd10_pkg::SER_BURST && tx_ev && tx_pd_n_s
      |=> ser_word_q == sd10_pkg::SYNC_PATTERN && ser_strobe_q;
  endproperty
  a_burst_pattern: assert property (p_burst_pattern) else $error("burst frame not sync pattern");

  property p_burst_hold;
    ser_st_q == sd10_pkg::SER_BURST && tx_ev && burst_cnt_q == sd10_pkg::SYNC_BURST_LAST &&
      req_any && tx_pd_n_s |=> ser_st_q == sd10_pkg::SER_HOLD;
  endproperty
  a_burst_hold: assert property (p_burst_hold) else $error("held request did not extend burst");

  property p_data_frame;
    ser_st_q == sd10_pkg::SER_DATA && tx_ev
      |=> ser_word_q[0] == sd10_pkg::START_BIT && ser_word_q[11] == sd10_pkg::STOP_BIT &&
          ser_word_q[10:1] == $past(din_s);
  endproperty
  a_data_frame: assert property (p_data_frame) else $error("data frame malformed");

  property p_init_float;
    ser_st_q == sd10_pkg::SER_INIT ##1 ser_st_q == sd10_pkg::SER_INIT |-> ser_oe_n_q;
  endproperty
  a_init_float: assert property (p_init_float) else $error("driver on during init");

  property p_lock_entry;
    des_st_q == sd10_pkg::DES_HUNT ##1 des_st_q == sd10_pkg::DES_LOCK
      |-> $past(match_cnt_q) == sd10_pkg::LOCK_MATCH - 3'h1 && !$past(repetitive_multitransition) ##1 !lock_n_q;
  endproperty
  a_lock_entry: assert property (p_lock_entry) else $error("lock without four matches");

  property p_lock_loss;
    des_st_q == sd10_pkg::DES_LOCK && rx_ev && !cand[pos_q] &&
      miss_cnt_q == sd10_pkg::LOSS_MISS - 3'h1 |=> des_st_q == sd10_pkg::DES_HUNT ##1 lock_n_q;
  endproperty
  a_lock_loss: assert property (p_lock_loss) else $error("lock kept after four misses");

  property p_unlocked_float;
    des_st_q != sd10_pkg::DES_LOCK |=> par_oe_n_q;
  endproperty
  a_unlocked_float: assert property (p_unlocked_float) else $error("outputs driven unlocked");

  property p_rclk_still;
    !rclk_en [*2] |=> $stable(rclk_q) || $past(rx_sel_s) != $past(rx_sel_s, 2);
  endproperty
  a_rclk_still: assert property (p_rclk_still) else $error("recovered clock toggles disabled");

  c_burst: cover property (ser_st_q == sd10_pkg::SER_DATA ##1 ser_st_q == sd10_pkg::SER_BURST);
  c_hold: cover property (ser_st_q == sd10_pkg::SER_HOLD ##1 ser_st_q == sd10_pkg::SER_DATA);
  c_lock: cover property (des_st_q == sd10_pkg::DES_HUNT ##1 des_st_q == sd10_pkg::DES_LOCK);
  c_unlock: cover property (des_st_q == sd10_pkg::DES_LOCK ##1 des_st_q == sd10_pkg::DES_HUNT);

endmodule : sd10_serdes
`default_nettype wire

/* File: shared/sd10_pkg.sv */
package sd10_pkg;

  // word and frame geometry
  localparam int DATA_W = 10;
  localparam int FRAME_W = 12;
  localparam int POS_W = 4;

  // framing bits: start at frame bit 0, stop at frame bit 11
  localparam logic START_BIT = 1'b1;
  localparam logic STOP_BIT = 1'b0;
  // six ones then six zeros, bit 0 sent first
  localparam logic [11:0] SYNC_PATTERN = 12'h03f;

  // sync request qualification and burst length, in transmit clock cycles
  localparam logic [2:0] SYNC_HOLD_CYCLES = 3'h6;
  localparam logic [10:0] SYNC_BURST_LEN = 11'h402;
  localparam logic [10:0] SYNC_BURST_LAST = SYNC_BURST_LEN - 11'h001;
  // reinitialisation after power-down, in transmit clock cycles
  localparam logic [10:0] INIT_LEN = 11'h402;
  localparam logic [10:0] INIT_LAST = INIT_LEN - 11'h001;

  // boundary search: words needed to lock and misses needed to unlock
  localparam logic [2:0] LOCK_MATCH = 3'h4;
  localparam logic [2:0] LOSS_MISS = 3'h4;

  // recovered clock shape, in system clock cycles after a new word
  localparam int CLK_PERIOD_NS = 40;
  localparam int RCLK_SETUP_NS = 80;
  localparam int RCLK_HIGH_NS = 120;
  localparam logic [2:0] RCLK_SETUP_CYC = 3'((RCLK_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] RCLK_END_CYC =
    3'((RCLK_SETUP_NS + RCLK_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {SER_INIT, SER_DATA, SER_BURST, SER_HOLD} sd10_ser_state_t;
  typedef enum logic {DES_HUNT, DES_LOCK} sd10_des_state_t;

  // serializer side of the link
  typedef struct packed {
    logic oe_n;
    logic strobe;
    logic [FRAME_W-1:0] word;
  } sd10_ser_link_t;

  // deserializer parallel side
  typedef struct packed {
    logic [DATA_W-1:0] parallel_out;
    logic parallel_oe_n;
    logic recovered_clock;
    logic recovered_clock_oe_n;
    logic lock_n;
    logic lock_oe_n;
  } sd10_rx_out_t;

endpackage : sd10_pkg

/* File: logic/sd10_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for pins from outside the clock domain
module sd10_sync #(
  parameter int WIDTH = 16
) (
  input wire logic clk, // system clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic [WIDTH-1:0] d, // asynchronous pins
  output logic [WIDTH-1:0] q // synchronised copy
);
  logic [WIDTH-1:0] meta_q;

  // the first stage feeds only the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : sd10_sync
`default_nettype wire

/* File: tb/sd10_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module sd10_partner (
  input wire logic en, // link active
  input wire logic sync, // send sync patterns
  input wire logic framed, // add start and stop bits
  input wire logic [9:0] data, // next word to send
  output logic link_clock, // word clock, stands low while idle
  output logic [11:0] link_word, // frame word
  output logic [9:0] cur_data, // data bits of the word sent before the last rise
  output int n_words // rising edges sent
);
  logic idle;
  logic [9:0] last_data;
  function automatic logic [11:0] frame();
    if (sync) return sd10_pkg::SYNC_PATTERN;
    return framed ? {sd10_pkg::STOP_BIT, data, sd10_pkg::START_BIT} : {2'b00, data};
  endfunction : frame
  initial begin
    link_clock = 1'b0;
    link_word = 12'h000;
    cur_data = 10'h000;
    last_data = 10'h000;
    n_words = 0;
    idle = 1'b1;
    #37;
    forever begin
      #160;
      if (link_clock) begin
        link_clock = 1'b0;
        link_word = frame();
      end else if (en && !idle) begin
        link_clock = 1'b1;
        // the receiver frames a word only once the next one arrives
        cur_data = last_data;
        last_data = link_word[10:1];
        n_words = n_words + 1;
      end else if (en) begin
        // a proper word is set up before the first rise after idle
        link_word = frame();
        idle = 1'b0;
      end else begin
        // released line must not keep showing the last word
        link_word = ~link_word;
        idle = 1'b1;
      end
    end
  end
endmodule : sd10_partner
`default_nettype wire

/* File: tb/serdes_10b_embedded_clock_link_test.sv */
`timescale 1ns/1ps
`default_nettype none
module serdes_10b_embedded_clock_link_test;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic TRANSMIT_CLOCK = 1'b0;
  logic TX_EDGE_SELECT = 1'b1;
  logic SYNC_REQUEST_A = 1'b0;
  logic SYNC_REQUEST_B = 1'b0;
  logic [9:0] PARALLEL_IN = 10'h000;
  logic SERIAL_DRIVER_ENABLE = 1'b1;
  logic TX_POWER_DOWN_N = 1'b1;
  sd10_pkg::sd10_ser_link_t SER_LINK;
  logic RX_LINK_CLOCK;
  logic [11:0] RX_LINK_WORD;
  logic RX_EDGE_SELECT = 1'b1;
  logic RX_POWER_DOWN_N = 1'b1;
  logic RX_OUTPUT_ENABLE = 1'b1;
  sd10_pkg::sd10_rx_out_t RX_OUT;
  logic rx_en = 1'b0;
  logic rx_sync = 1'b0;
  logic rx_framed = 1'b1;
  logic [9:0] rx_data = 10'h000;
  logic [9:0] cur_data;
  logic [9:0] exp_r = 10'h000;
  logic [9:0] exp_f = 10'h000;
  logic [11:0] exp_w;
  logic rc_q = 1'b1;
  int n_words;
  int n_errors = 0;
  int tests_run = 0;
  int tc_cnt = 0;
  int n_strobe = 0;
  int sync_run = 0;
  int last_run = 0;
  int since = 0;
  int n_rxs = 0;
  integer seed = 32'heb1acc3a;

  sd10_serdes dut_u (
    .CLK(CLK), .RESETN(RESETN), .TRANSMIT_CLOCK(TRANSMIT_CLOCK),
    .TX_EDGE_SELECT(TX_EDGE_SELECT), .SYNC_REQUEST_A(SYNC_REQUEST_A),
    .SYNC_REQUEST_B(SYNC_REQUEST_B), .PARALLEL_IN(PARALLEL_IN),
    .SERIAL_DRIVER_ENABLE(SERIAL_DRIVER_ENABLE), .TX_POWER_DOWN_N(TX_POWER_DOWN_N),
    .SER_LINK(SER_LINK), .RX_LINK_CLOCK(RX_LINK_CLOCK), .RX_LINK_WORD(RX_LINK_WORD),
    .RX_EDGE_SELECT(RX_EDGE_SELECT), .RX_POWER_DOWN_N(RX_POWER_DOWN_N),
    .RX_OUTPUT_ENABLE(RX_OUTPUT_ENABLE), .RX_OUT(RX_OUT)
  );
  sd10_partner partner_u (
    .en(rx_en), .sync(rx_sync), .framed(rx_framed), .data(rx_data),
    .link_clock(RX_LINK_CLOCK), .link_word(RX_LINK_WORD), .cur_data(cur_data),
    .n_words(n_words)
  );

  always #20 CLK = ~CLK;

  function automatic logic [9:0] mk_data();
    logic [9:0] d;
    d = 10'($random(seed));
    // keep data words distinguishable from the sync pattern
    return (d == 10'h01f) ? 10'h01e : d;
  endfunction : mk_data

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task complete_run();
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  // scaled source clock
  // word clock of 12 cycles; data moves 3 cycles after each edge
  always @(negedge CLK) begin
    tc_cnt <= (tc_cnt == 11) ? 0 : tc_cnt + 1;
    TRANSMIT_CLOCK <= (tc_cnt < 6);
    if (tc_cnt == 0) exp_r <= PARALLEL_IN;
    if (tc_cnt == 6) exp_f <= PARALLEL_IN;
    if (tc_cnt == 3 || tc_cnt == 9) PARALLEL_IN <= mk_data();
  end

  always @(negedge CLK) begin
    if (RESETN && SER_LINK.strobe === 1'b1) begin
      n_strobe++;
      if (SER_LINK.word === sd10_pkg::SYNC_PATTERN) begin
        sync_run++;
        since = 0;
        if (sync_run > 1) check(12'(SER_LINK.oe_n), 12'(!SERIAL_DRIVER_ENABLE));
      end else begin
        if (sync_run > 0) last_run = sync_run;
        sync_run = 0;
        exp_w = {sd10_pkg::STOP_BIT, TX_EDGE_SELECT ? exp_r : exp_f, sd10_pkg::START_BIT};
        check(SER_LINK.word, exp_w);
        if (since > 0) check(12'(SER_LINK.oe_n), 12'(!(SERIAL_DRIVER_ENABLE &&
          !(SYNC_REQUEST_A || SYNC_REQUEST_B))));
        since++;
      end
    end
  end

  always @(negedge CLK) begin
    if (RESETN) begin
      if (RX_OUT.lock_n === 1'b1)
        check({RX_OUT.parallel_oe_n, RX_OUT.recovered_clock_oe_n}, 12'h003);
      if (RX_OUT.recovered_clock !== rc_q && RX_OUT.recovered_clock_oe_n === 1'b0) begin
        check(12'(RX_OUT.lock_n), 12'h000);
        if (RX_OUT.recovered_clock === RX_EDGE_SELECT) begin
          n_rxs++;
          check(12'(RX_OUT.parallel_out), 12'(cur_data));
        end
      end
    end
    rc_q = RX_OUT.recovered_clock;
  end

  task tx_wait(input int n);
    repeat (n) begin
      @(negedge CLK);
      while (tc_cnt != (TX_EDGE_SELECT ? 8 : 2)) @(negedge CLK);
    end
  endtask : tx_wait

  task tx_data(input int n);
    int s0;
    s0 = n_strobe;
    tx_wait(n);
    check(12'(n_strobe - s0), 12'(n)); // one word per clock
  endtask : tx_data

  task tx_init_check();
    int s0;
    s0 = n_strobe;
    since = 0;
    tx_wait(1020);
    check(12'(n_strobe - s0), 12'h000); // silent while initialising
    check(12'(SER_LINK.oe_n), 12'h001);
    tx_wait(12);
    check(12'(n_strobe > s0), 12'h001); // words resume
  endtask : tx_init_check

  task rx_words(input int k);
    int w;
    w = n_words + k;
    while (n_words < w) @(negedge CLK);
    repeat (6) @(negedge CLK);
  endtask : rx_words

  task rx_rand(input int n);
    repeat (n) begin
      rx_words(1);
      rx_data = mk_data();
    end
  endtask : rx_rand

  initial begin
    #3600000;
    n_errors++;
    complete_run();
  end

  initial begin
    repeat (10) @(negedge CLK);
    RESETN = 1'b1;
    tx_init_check();
    tx_data(30);
    SERIAL_DRIVER_ENABLE = 1'b0;
    tx_data(5);
    SERIAL_DRIVER_ENABLE = 1'b1;
    tx_data(5);
    SYNC_REQUEST_A = 1'b1;
    tx_wait(8);
    SYNC_REQUEST_A = 1'b0;
    tx_wait(300);
    SERIAL_DRIVER_ENABLE = 1'b0;
    tx_wait(20);
    SERIAL_DRIVER_ENABLE = 1'b1;
    tx_wait(720);
    check(12'(last_run), 12'(sd10_pkg::SYNC_BURST_LEN)); // exact burst
    TX_POWER_DOWN_N = 1'b0;
    tx_wait(3);
    check(12'(SER_LINK.oe_n), 12'h001);
    TX_EDGE_SELECT = 1'b0;
    tx_wait(3);
    TX_POWER_DOWN_N = 1'b1;
    tx_init_check();
    tx_data(30);
    SYNC_REQUEST_B = 1'b1;
    tx_wait(1040);
    SYNC_REQUEST_B = 1'b0;
    tx_wait(10);
    check(12'(last_run >= 1030 && last_run <= 1042), 12'h001); // held request
    rx_data = 10'h002;
    rx_en = 1'b1;
    rx_words(8);
    check(12'(RX_OUT.lock_n), 12'h001); // repeated pattern blocks lock
    rx_sync = 1'b1;
    rx_words(3);
    check(12'(RX_OUT.lock_n), 12'h001); // not before four
    rx_words(3);
    check({RX_OUT.lock_n, RX_OUT.lock_oe_n}, 12'h000);
    rx_sync = 1'b0;
    rx_rand(20);
    rx_en = 1'b0;
    repeat (10) @(negedge CLK);
    RX_EDGE_SELECT = 1'b0;
    repeat (10) @(negedge CLK);
    rx_en = 1'b1;
    rx_rand(20);
    check(12'(n_rxs > 30), 12'h001); // strobes seen
    RX_OUTPUT_ENABLE = 1'b0;
    rx_words(2);
    check({RX_OUT.parallel_oe_n, RX_OUT.recovered_clock_oe_n, RX_OUT.lock_n,
      RX_OUT.lock_oe_n}, 12'h00c);
    RX_POWER_DOWN_N = 1'b0;
    RX_OUTPUT_ENABLE = 1'b1;
    rx_words(2);
    check({RX_OUT.parallel_oe_n, RX_OUT.lock_n, RX_OUT.lock_oe_n}, 12'h000);
    RX_OUTPUT_ENABLE = 1'b0;
    rx_words(2);
    check({RX_OUT.parallel_oe_n, RX_OUT.lock_oe_n}, 12'h003);
    RX_POWER_DOWN_N = 1'b1;
    RX_OUTPUT_ENABLE = 1'b1;
    rx_words(1);
    check(12'(RX_OUT.lock_n), 12'h001); // hunting again
    rx_sync = 1'b1;
    rx_words(6);
    check(12'(RX_OUT.lock_n), 12'h000);
    rx_sync = 1'b0;
    rx_framed = 1'b0;
    rx_data = 10'h000;
    rx_words(3);
    check(12'(RX_OUT.lock_n), 12'h000); // one miss keeps lock
    rx_words(3);
    check({RX_OUT.lock_n, RX_OUT.parallel_oe_n}, 12'h003);
    complete_run();
  end
endmodule : serdes_10b_embedded_clock_link_test
`default_nettype wire
